/* core/ocic_pkg.sv */
// package of the on-chip interrupt controller: offsets, fields, resets
// assumes: included before every core file, used only as ocic_pkg::name
package ocic_pkg;

  // ----------------------------------------------------------------
  // register map (word index on the register port)
  // ----------------------------------------------------------------
  localparam logic [2:0] OFF_PENDING = 3'h0;
  localparam logic [2:0] OFF_SRC_MASK = 3'h1;
  localparam logic [2:0] OFF_IN_SERVICE = 3'h2;
  localparam logic [2:0] OFF_EVT_STATUS = 3'h3;
  localparam logic [2:0] OFF_EVT_MASK = 3'h4;
  localparam logic [2:0] OFF_CONFIG = 3'h5;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int CFG_DED_BIT = 0;
  localparam int CFG_VBASE_LSB = 8;
  localparam int VBASE_W = 3;
  localparam int EVT_ACK = 0;
  localparam int EVT_ERRVEC = 1;
  localparam int EVT_EXT_RSV = 2;
  localparam int EVT_W = 3;
  localparam logic [15:0] RST_SRC_MASK = 16'h0000;
  localparam logic [15:0] RST_IN_SERVICE = 16'h0000;
  localparam logic [15:0] RST_CONFIG = 16'h0000;
  localparam logic [2:0] RST_EVT = 3'h0;

  // ----------------------------------------------------------------
  // priority levels and acknowledge cycle encoding
  // ----------------------------------------------------------------
  localparam logic [2:0] LVL_NONE = 3'h0;
  localparam logic [2:0] LVL_ONE = 3'h1;
  localparam logic [2:0] LVL_INTERNAL = 3'h4;
  localparam logic [2:0] LVL_SIX = 3'h6;
  localparam logic [2:0] LVL_SEVEN = 3'h7;
  localparam logic [2:0] FC_IACK = 3'h7;
  localparam logic [3:0] IACK_ADDR_HI = 4'hF;

  typedef enum logic [1:0] {
    OCIC_IDLE = 2'b01,
    OCIC_DRIVE = 2'b10
  } ocic_ack_type;

endpackage : ocic_pkg

/* core/ocic_prio.sv */
// highest-set-bit encoder for the interrupt controller
// assumes: purely combinational, used inside one clock domain
`timescale 1ns/1ps
`default_nettype none

module ocic_prio #(
  parameter int W = 16,
  parameter int IW = 4
) (
  input wire logic [W-1:0] vec_i,
  output logic found_o,
  output logic [IW-1:0] idx_o
);

  if ((1 << IW) < W) begin : g_bad_index
    $error("ocic_prio: index too narrow");
  end

  // ----------------------------------------------------------------
  // scan upward so the highest-numbered set bit is kept
  // ----------------------------------------------------------------
  always_comb begin
    found_o = 1'b0;
    idx_o = '0;
    for (int i = 0; i < W; i++) begin
      if (vec_i[i]) begin
        found_o = 1'b1;
        idx_o = IW'(i);
      end
    end
  end

endmodule : ocic_prio

`default_nettype wire

/* core/ocic_top.sv */
// on-chip interrupt controller: internal sources, external levels,
// in-service nesting and vector answer to the core acknowledge cycle
// assumes: core and peripherals run on CLK_I; external pins do not
//
// Notes on behaviour
// RL1 - accept internal requests: timers, dma, serial channels, port pins 11 to 8
// RL2 - one mask bit per internal source; per-event masks stay in peripherals
// RL3 - external requests encoded on three lines, or three dedicated lines 7,6,1
// RL4 - encoded mode gives seven levels; level 4 belongs to internal requests
// RL5 - sixteen-bit in-service register, one bit per source, readable
// RL6 - in-service bit set when that source's vector goes to the core
// RL7 - writing one clears an in-service bit; zero leaves it; never settable
// RL8 - reset clears all in-service bits
// RL9 - request presented only above highest in-service source
// RL10 - error vector leaves in-service bits unchanged
// RL11 - in-service bit 0 always reads zero
// RL12 - single-event source pending cleared during acknowledge
// RL13 - multi-event source pending follows its unmasked peripheral events
// RL14 - handler clears in-service bit and peripheral events itself
// RL15 - acknowledge: read, code 111, level on a3..a1, upper nibble high, both strobes
// RL16 - on acknowledge drive the requesting source's vector
// RL17 - fixed internal priority, highest-numbered set bit wins
`timescale 1ns/1ps
`default_nettype none

module ocic_top #(
  parameter int NSRC = 16,
  // set bit: source has several events and holds its request as a level
  parameter logic [15:0] MULTI_EVENT = 16'h0000
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [15:0] INT_REQ_I,
  input wire logic [2:0] EXT_PRIO_N_I,
  input wire logic EXT_LVL7_N_I,
  input wire logic EXT_LVL6_N_I,
  input wire logic EXT_LVL1_N_I,
  input wire logic CORE_AS_I,
  input wire logic CORE_RW_I,
  input wire logic CORE_UDS_I,
  input wire logic CORE_LDS_I,
  input wire logic [2:0] CORE_FC_I,
  input wire logic [3:0] CORE_ADDR_HI_I,
  input wire logic [2:0] CORE_LEVEL_I,
  input wire logic [2:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [15:0] REG_RDATA_O,
  output logic [2:0] CORE_IPL_O,
  output logic [7:0] VECTOR_O,
  output logic VECTOR_VALID_O,
  output logic HOST_IRQ_O
);

  if (NSRC != 16) begin : g_bad_nsrc
    $error("ocic_top: exactly sixteen sources are served");
  end

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
    hit = (a == off);
  endfunction : hit

  wire wr_pend = REG_WR_I && hit(REG_ADDR_I, ocic_pkg::OFF_PENDING);
  wire wr_mask = REG_WR_I && hit(REG_ADDR_I, ocic_pkg::OFF_SRC_MASK);
  wire wr_isr = REG_WR_I && hit(REG_ADDR_I, ocic_pkg::OFF_IN_SERVICE);
  wire wr_est = REG_WR_I && hit(REG_ADDR_I, ocic_pkg::OFF_EVT_STATUS);
  wire wr_emsk = REG_WR_I && hit(REG_ADDR_I, ocic_pkg::OFF_EVT_MASK);
  wire wr_cfg = REG_WR_I && hit(REG_ADDR_I, ocic_pkg::OFF_CONFIG);

  // ----------------------------------------------------------------
  // external pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] ext_s1_r;
  logic [5:0] ext_s2_r;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ext_s1_r <= 6'h3F;
      ext_s2_r <= 6'h3F;
    end else begin
      ext_s1_r <= {EXT_LVL7_N_I, EXT_LVL6_N_I, EXT_LVL1_N_I, EXT_PRIO_N_I};
      ext_s2_r <= ext_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // configuration and masks
  // ----------------------------------------------------------------
  logic [15:0] cfg_r;
  logic [15:0] src_mask_r;
  wire dedicated = cfg_r[ocic_pkg::CFG_DED_BIT];
  wire [2:0] vbase = cfg_r[ocic_pkg::CFG_VBASE_LSB +: ocic_pkg::VBASE_W];

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cfg_r <= ocic_pkg::RST_CONFIG;
    end else if (wr_cfg) begin
      cfg_r <= REG_WDATA_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      src_mask_r <= ocic_pkg::RST_SRC_MASK;
    end else if (wr_mask) begin
      src_mask_r <= REG_WDATA_I; // [RL2]
    end
  end

  // ----------------------------------------------------------------
  // external level
  // ----------------------------------------------------------------
  logic [2:0] ext_lvl;
  wire [2:0] ext_enc = ~ext_s2_r[2:0];
  wire ext_rsv = !dedicated && (ext_enc == ocic_pkg::LVL_INTERNAL);

  always_comb begin
    ext_lvl = ocic_pkg::LVL_NONE;
    if (dedicated) begin
      if (!ext_s2_r[5]) begin
        ext_lvl = ocic_pkg::LVL_SEVEN; // [RL3]
      end else if (!ext_s2_r[4]) begin
        ext_lvl = ocic_pkg::LVL_SIX; // [RL3]
      end else if (!ext_s2_r[3]) begin
        ext_lvl = ocic_pkg::LVL_ONE; // [RL3]
      end
    end else if (!ext_rsv) begin
      // level 4 from outside is dropped, it would alias internal requests
      ext_lvl = ext_enc; // [RL3] [RL4]
    end
  end

  // ----------------------------------------------------------------
  // acknowledge recognition
  // ----------------------------------------------------------------
  ocic_pkg::ocic_ack_type st_r;
  wire iack_cyc = CORE_AS_I && CORE_RW_I && CORE_UDS_I && CORE_LDS_I
                  && (CORE_FC_I == ocic_pkg::FC_IACK)
                  && (CORE_ADDR_HI_I == ocic_pkg::IACK_ADDR_HI)
                  && (CORE_LEVEL_I == ocic_pkg::LVL_INTERNAL); // [RL15]
  wire iack_take = iack_cyc && (st_r == ocic_pkg::OCIC_IDLE);

  // ----------------------------------------------------------------
  // pending bits
  // ----------------------------------------------------------------
  logic [15:0] req_d_r;
  logic [15:0] pend_r;
  logic [15:0] ack_oh;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      req_d_r <= 16'h0000;
    end else begin
      req_d_r <= INT_REQ_I;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_pend
      if (MULTI_EVENT[g]) begin : g_multi
        always_ff @(posedge CLK_I) begin
          if (!RST_N_I) begin
            pend_r[g] <= 1'b0;
          end else begin
            pend_r[g] <= INT_REQ_I[g]; // [RL13] [RL1]
          end
        end
      end else begin : g_single
        always_ff @(posedge CLK_I) begin
          if (!RST_N_I) begin
            pend_r[g] <= 1'b0;
          end else if (INT_REQ_I[g] && !req_d_r[g]) begin
            pend_r[g] <= 1'b1; // [RL1]
          end else if (ack_oh[g] || (wr_pend && REG_WDATA_I[g])) begin
            pend_r[g] <= 1'b0; // [RL12]
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // nesting: compare best candidate with highest in-service source
  // ----------------------------------------------------------------
  logic [15:0] isr_r;
  logic cand_f;
  logic isr_f;
  logic [3:0] cand_i;
  logic [3:0] isr_i;
  wire [15:0] cand = pend_r & src_mask_r & 16'hFFFE; // [RL2]

  ocic_prio #(.W(16), .IW(4)) u_cand (
    .vec_i(cand),
    .found_o(cand_f),
    .idx_o(cand_i) // [RL17]
  );

  ocic_prio #(.W(16), .IW(4)) u_isr (
    .vec_i(isr_r),
    .found_o(isr_f),
    .idx_o(isr_i)
  );

  wire present = cand_f && (!isr_f || (cand_i > isr_i)); // [RL9]
  assign ack_oh = (iack_take && present) ? (16'h0001 << cand_i) : 16'h0000;

  // ----------------------------------------------------------------
  // in-service bits: set wins over a same-cycle clear
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      isr_r <= ocic_pkg::RST_IN_SERVICE; // [RL8]
    end else begin
      // a bad acknowledge leaves ack_oh empty, so nothing is set here
      isr_r <= ((isr_r & ~(wr_isr ? REG_WDATA_I : 16'h0000)) | ack_oh)
               & 16'hFFFE; // [RL6] [RL7] [RL10] [RL11] [RL5]
    end
  end

  // ----------------------------------------------------------------
  // vector answer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      st_r <= ocic_pkg::OCIC_IDLE;
    end else begin
      case (st_r)
        ocic_pkg::OCIC_IDLE: begin
          if (iack_cyc) begin
            st_r <= ocic_pkg::OCIC_DRIVE;
          end
        end
        ocic_pkg::OCIC_DRIVE: begin
          if (!CORE_AS_I) begin
            st_r <= ocic_pkg::OCIC_IDLE;
          end
        end
        default: begin
          st_r <= ocic_pkg::OCIC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      VECTOR_O <= 8'h00;
      VECTOR_VALID_O <= 1'b0;
    end else begin
      if (iack_take) begin
        // source 0 slot doubles as the error vector
        VECTOR_O <= {vbase, 1'b0, present ? cand_i : 4'h0}; // [RL16] [RL10]
        VECTOR_VALID_O <= 1'b1;
      end else if (!iack_cyc) begin
        VECTOR_VALID_O <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // level to the core
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      CORE_IPL_O <= ocic_pkg::LVL_NONE;
    end else if (present && (ext_lvl < ocic_pkg::LVL_INTERNAL)) begin
      CORE_IPL_O <= ocic_pkg::LVL_INTERNAL; // [RL4]
    end else begin
      CORE_IPL_O <= ext_lvl;
    end
  end

  // ----------------------------------------------------------------
  // host events: sticky, write one to clear, set wins
  // ----------------------------------------------------------------
  logic [2:0] est_r;
  logic [2:0] emsk_r;
  logic [2:0] evt;

  assign evt[ocic_pkg::EVT_ACK] = iack_take && present;
  assign evt[ocic_pkg::EVT_ERRVEC] = iack_take && !present;
  assign evt[ocic_pkg::EVT_EXT_RSV] = ext_rsv; // [RL4]

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      est_r <= ocic_pkg::RST_EVT;
    end else begin
      est_r <= (est_r & ~(wr_est ? REG_WDATA_I[2:0] : 3'h0)) | evt;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      emsk_r <= ocic_pkg::RST_EVT;
    end else if (wr_emsk) begin
      emsk_r <= REG_WDATA_I[2:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      HOST_IRQ_O <= 1'b0;
    end else begin
      HOST_IRQ_O <= |(((est_r & ~(wr_est ? REG_WDATA_I[2:0] : 3'h0)) | evt)
                      & (wr_emsk ? REG_WDATA_I[2:0] : emsk_r));
    end
  end

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe, zero elsewhere
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O <= 16'h0000;
    end else if (REG_RD_I) begin
      case (REG_ADDR_I)
        ocic_pkg::OFF_PENDING: REG_RDATA_O <= pend_r;
        ocic_pkg::OFF_SRC_MASK: REG_RDATA_O <= src_mask_r;
        ocic_pkg::OFF_IN_SERVICE: REG_RDATA_O <= isr_r; // [RL5] [RL11]
        ocic_pkg::OFF_EVT_STATUS: REG_RDATA_O <= {13'h0, est_r};
        ocic_pkg::OFF_EVT_MASK: REG_RDATA_O <= {13'h0, emsk_r};
        ocic_pkg::OFF_CONFIG: REG_RDATA_O <= cfg_r;
        default: REG_RDATA_O <= 16'h0000;
      endcase
    end else begin
      REG_RDATA_O <= 16'h0000;
    end
  end

endmodule : ocic_top

`default_nettype wire

/* dv/ocic_monitor.sv */
// checker of the interrupt controller top ports
// assumes: bound onto ocic_top, one clock CLK_I
`timescale 1ns/1ps
`default_nettype none

module ocic_monitor (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CORE_AS_I,
  input wire logic CORE_RW_I,
  input wire logic CORE_UDS_I,
  input wire logic CORE_LDS_I,
  input wire logic [2:0] CORE_FC_I,
  input wire logic [3:0] CORE_ADDR_HI_I,
  input wire logic [2:0] CORE_LEVEL_I,
  input wire logic [2:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [15:0] REG_RDATA_O,
  input wire logic [2:0] CORE_IPL_O,
  input wire logic [7:0] VECTOR_O,
  input wire logic VECTOR_VALID_O,
  input wire logic HOST_IRQ_O
);
  // --------------------------------------------------------------
  // acknowledge decode and assertions
  // --------------------------------------------------------------
  wire ack_q = CORE_AS_I && CORE_RW_I && CORE_UDS_I && CORE_LDS_I
    && CORE_FC_I == ocic_pkg::FC_IACK && CORE_ADDR_HI_I == ocic_pkg::IACK_ADDR_HI
    && CORE_LEVEL_I == ocic_pkg::LVL_INTERNAL;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_reset_outputs: assert property (disable iff (1'b0) !RST_N_I |=>
    REG_RDATA_O == 16'h0000 && CORE_IPL_O == 3'h0 && !VECTOR_VALID_O && !HOST_IRQ_O)
    else $error("outputs not clear after reset");
  a_rdata_idle: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 16'h0000)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (
    $past(REG_RD_I) && $past(REG_ADDR_I) > ocic_pkg::OFF_CONFIG |-> REG_RDATA_O == 16'h0000)
    else $error("unmapped read not zero");
  a_isr_bit0: assert property (
    $past(REG_RD_I) && $past(REG_ADDR_I) == ocic_pkg::OFF_IN_SERVICE |-> !REG_RDATA_O[0])
    else $error("in-service bit 0 read as one");
  a_isr_w1c: assert property (REG_WR_I && REG_ADDR_I == ocic_pkg::OFF_IN_SERVICE
    && REG_WDATA_I == 16'hFFFF && !ack_q ##1 REG_RD_I && !ack_q
    && REG_ADDR_I == ocic_pkg::OFF_IN_SERVICE |=> REG_RDATA_O == 16'h0000)
    else $error("in-service bits survive a clearing write");
  a_vec_needs_ack: assert property ($rose(VECTOR_VALID_O) |-> $past(ack_q))
    else $error("vector without acknowledge");
  a_vec_drops: assert property (VECTOR_VALID_O && !ack_q |=> !VECTOR_VALID_O)
    else $error("vector held after acknowledge ended");
  a_vec_held: assert property (
    VECTOR_VALID_O && $past(VECTOR_VALID_O) |-> $stable(VECTOR_O))
    else $error("vector changed while valid");
endmodule : ocic_monitor

bind ocic_top ocic_monitor u_ocic_monitor (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .CORE_AS_I(CORE_AS_I), .CORE_RW_I(CORE_RW_I), .CORE_UDS_I(CORE_UDS_I),
  .CORE_LDS_I(CORE_LDS_I), .CORE_FC_I(CORE_FC_I), .CORE_ADDR_HI_I(CORE_ADDR_HI_I),
  .CORE_LEVEL_I(CORE_LEVEL_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
  .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
  .CORE_IPL_O(CORE_IPL_O), .VECTOR_O(VECTOR_O), .VECTOR_VALID_O(VECTOR_VALID_O),
  .HOST_IRQ_O(HOST_IRQ_O));
`default_nettype wire

/* dv/ocic_core_model.sv */
// processor core model running interrupt acknowledge cycles
// assumes: one request pulse per cycle wanted, same clock as the controller
`timescale 1ns/1ps
`default_nettype none

module ocic_core_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic [2:0] lvl_i,
  input wire logic [1:0] slow_i,
  input wire logic valid_i,
  input wire logic [7:0] vector_i,
  output logic as_o,
  output logic rw_o,
  output logic uds_o,
  output logic lds_o,
  output logic [2:0] fc_o,
  output logic [3:0] ahi_o,
  output logic [2:0] lvl_o,
  output logic done_o,
  output logic got_o,
  output logic [7:0] vec_o
);
  // --------------------------------------------------------------
  // acknowledge cycle
  // --------------------------------------------------------------
  logic busy_r;
  logic [3:0] tmo_r;
  logic [3:0] pat_r;
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    pat_r <= pat_r + 4'h1;
    if (rst_n_i && busy_r) begin
      tmo_r <= tmo_r + 4'h1;
      // vector taken at the edge it is seen, after an optional stall
      if ((valid_i && tmo_r >= {2'h0, slow_i}) || tmo_r == 4'hF) begin
        busy_r <= 1'b0;
        as_o <= 1'b0;
        done_o <= 1'b1;
        got_o <= valid_i;
        vec_o <= vector_i;
      end
    end else if (rst_n_i && req_i) begin
      busy_r <= 1'b1;
      tmo_r <= 4'h0;
      as_o <= 1'b1;
      rw_o <= 1'b1;
      uds_o <= 1'b1;
      lds_o <= 1'b1;
      fc_o <= 3'h7;
      ahi_o <= 4'hF;
      lvl_o <= lvl_i;
    end else begin
      // released lines wander so a stale value never looks driven
      busy_r <= 1'b0;
      as_o <= 1'b0;
      rw_o <= pat_r[0];
      uds_o <= pat_r[1];
      lds_o <= pat_r[2];
      fc_o <= pat_r[2:0];
      ahi_o <= pat_r;
      lvl_o <= ~pat_r[2:0];
      if (!rst_n_i) pat_r <= 4'h0;
    end
  end
endmodule : ocic_core_model
`default_nettype wire

/* dv/ocic_tb_top.sv */
// testbench of the interrupt controller: registers, acknowledge, nesting
// assumes: core model answers acknowledge cycles, monitor bound on ocic_top
`timescale 1ns/1ps
`default_nettype none

module ocic_tb_top;
  logic clk, as, rw, uds, lds, vv, irq, mdone, mgot;
  logic rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, mreq = 1'b0;
  logic l7 = 1'b1, l6 = 1'b1, l1 = 1'b1;
  logic [2:0] ra = 3'h0, xp = 3'h7, mlvl = 3'h0;
  logic [2:0] fc, lv, ipl;
  logic [3:0] ahi, s;
  logic [1:0] mslow = 2'h0;
  logic [7:0] vec, mvec;
  logic [15:0] ireq = 16'h0000, wd = 16'h0000, rdat;
  integer n_errors = 0, total_checks = 0, seed = 32'hA60D;

  ocic_top #(.MULTI_EVENT(16'h0100)) u_ocic_top (.CLK_I(clk), .RST_N_I(rst_n),
    .INT_REQ_I(ireq), .EXT_PRIO_N_I(xp), .EXT_LVL7_N_I(l7), .EXT_LVL6_N_I(l6),
    .EXT_LVL1_N_I(l1), .CORE_AS_I(as), .CORE_RW_I(rw), .CORE_UDS_I(uds), .CORE_LDS_I(lds),
    .CORE_FC_I(fc), .CORE_ADDR_HI_I(ahi), .CORE_LEVEL_I(lv), .REG_ADDR_I(ra),
    .REG_WDATA_I(wd), .REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_RDATA_O(rdat),
    .CORE_IPL_O(ipl), .VECTOR_O(vec), .VECTOR_VALID_O(vv), .HOST_IRQ_O(irq));
  ocic_core_model u_ocic_core_model (.clk_i(clk), .rst_n_i(rst_n), .req_i(mreq),
    .lvl_i(mlvl), .slow_i(mslow), .valid_i(vv), .vector_i(vec), .as_o(as), .rw_o(rw),
    .uds_o(uds), .lds_o(lds), .fc_o(fc), .ahi_o(ahi), .lvl_o(lv), .done_o(mdone),
    .got_o(mgot), .vec_o(mvec));

  // --------------------------------------------------------------
  // clock, checks and bus tasks
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic final_report();
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    ra <= a;
    wd <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  // optional write, then a read of the same word with no gap between
  task automatic acc(input logic w, input logic [2:0] a, input logic [15:0] d,
                     input logic [15:0] e);
    if (w) wr(a, d);
    else @(posedge clk);
    rd_s <= 1'b1;
    ra <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdat, e);
  endtask : acc
  task automatic pulse(input logic [15:0] m);
    @(posedge clk);
    ireq <= m;
    @(posedge clk);
    ireq <= 16'h0000;
    repeat (2) @(posedge clk);
  endtask : pulse
  task automatic ipl_is(input logic [2:0] e);
    repeat (8) begin
      @(posedge clk);
      #1;
      if (ipl === e) break;
    end
    chk(16'(ipl), 16'(e));
  endtask : ipl_is
  task automatic ack(input logic [2:0] l, input logic [7:0] e);
    @(posedge clk);
    mreq <= 1'b1;
    mlvl <= l;
    mslow <= 2'($random(seed));
    @(posedge clk);
    mreq <= 1'b0;
    repeat (30) begin
      @(posedge clk);
      #1;
      if (mdone) break;
    end
    chk(16'(mvec), 16'(e));
  endtask : ack

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    acc(0, ocic_pkg::OFF_IN_SERVICE, 0, 16'h0000);
    acc(0, 3'h7, 0, 16'h0000);
    acc(1, ocic_pkg::OFF_SRC_MASK, 16'hFFDE, 16'hFFDE);
    wr(ocic_pkg::OFF_CONFIG, 16'h0500);
    wr(ocic_pkg::OFF_EVT_MASK, 16'h0001);
    pulse(16'h0020);
    ipl_is(3'h0);
    wr(ocic_pkg::OFF_SRC_MASK, 16'hFFFE);
    ipl_is(3'h4);
    ack(3'h4, 8'hA5);
    repeat (6) begin
      s = 4'(1 + {$random(seed)} % 15);
      if (s == 4'h8) s = 4'h9;
      acc(1, ocic_pkg::OFF_IN_SERVICE, 16'hFFFF, 16'h0000);
      pulse(16'h0001 << s);
      ipl_is(3'h4);
      ack(3'h4, {3'h5, 1'b0, s});
      acc(0, ocic_pkg::OFF_PENDING, 0, 16'h0000);
      acc(1, ocic_pkg::OFF_IN_SERVICE, 16'h0000, 16'h0001 << s);
    end
    chk(16'(irq), 16'h0001);
    acc(1, ocic_pkg::OFF_IN_SERVICE, 16'hFFFF, 16'h0000);
    pulse(16'h1008);
    ipl_is(3'h4);
    ack(3'h4, 8'hAC);
    pulse(16'h2000);
    ipl_is(3'h4);
    ack(3'h4, 8'hAD);
    acc(1, ocic_pkg::OFF_IN_SERVICE, 16'h0000, 16'h3000);
    acc(1, ocic_pkg::OFF_IN_SERVICE, 16'h2000, 16'h1000);
    repeat (3) @(posedge clk);
    ipl_is(3'h0);
    acc(1, ocic_pkg::OFF_IN_SERVICE, 16'h1000, 16'h0000);
    ipl_is(3'h4);
    ack(3'h4, 8'hA3);
    ack(3'h4, 8'hA0);
    acc(1, ocic_pkg::OFF_IN_SERVICE, 16'h0000, 16'h0008);
    acc(1, ocic_pkg::OFF_IN_SERVICE, 16'hFFFF, 16'h0000);
    ack(3'h3, 8'hA0);
    chk(16'(mgot), 16'h0000);
    @(posedge clk);
    ireq <= 16'h0100;
    ipl_is(3'h4);
    ack(3'h4, 8'hA8);
    acc(1, ocic_pkg::OFF_IN_SERVICE, 16'h0100, 16'h0000);
    ipl_is(3'h4);
    acc(0, ocic_pkg::OFF_PENDING, 0, 16'h0100);
    @(posedge clk);
    ireq <= 16'h0000;
    acc(0, ocic_pkg::OFF_PENDING, 0, 16'h0000);
    acc(0, ocic_pkg::OFF_EVT_STATUS, 0, 16'h0003);
    acc(1, ocic_pkg::OFF_EVT_STATUS, 16'h0007, 16'h0000);
    repeat (2) @(posedge clk);
    chk(16'(irq), 16'h0000);
    for (int l = 1; l < 8; l++) begin
      @(posedge clk);
      xp <= ~3'(l);
      ipl_is(l == 4 ? 3'h0 : 3'(l));
    end
    acc(0, ocic_pkg::OFF_EVT_STATUS, 0, 16'h0004);
    wr(ocic_pkg::OFF_CONFIG, 16'h0501);
    l1 <= 1'b0;
    ipl_is(3'h1);
    @(posedge clk);
    l6 <= 1'b0;
    ipl_is(3'h6);
    @(posedge clk);
    l7 <= 1'b0;
    ipl_is(3'h7);
    @(posedge clk);
    {l7, l6, l1} <= 3'h7;
    ipl_is(3'h0);
    // leave an in-service bit set so the mid-run reset has something to clear
    pulse(16'h0002);
    ipl_is(3'h4);
    ack(3'h4, 8'hA1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    acc(0, ocic_pkg::OFF_IN_SERVICE, 0, 16'h0000);
    acc(0, ocic_pkg::OFF_SRC_MASK, 0, 16'h0000);
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report();
  end
endmodule : ocic_tb_top
`default_nettype wire
